// ### logic/pmm_pkg.sv
/*
  Constants and types for the program and data memory map of the core.
  Assumes a single core clock and one asynchronous active-high reset.
*/
// Overview of operation
// - A 13-bit program counter addresses a program store of 4K words of 14 bits.
// - Fetch addresses above the implemented 4K words wrap back into that region.
// - Any reset makes instruction fetch begin at program address 0000h.
// - An accepted interrupt redirects instruction fetch to program address 0004h.
// - In direct addressing two bank-select bits choose one of four data banks, low bit weighting one.
// - Each data bank spans in-bank offsets 00h to 7Fh, 128 byte locations.
// - Low offsets decode to special function registers (banks 2 and 3: shared ones only), higher ones to RAM, except bank 3 offsets 20h to 6Fh.
// - Frequently used special function registers reach one register from several banks.
// - General purpose storage is 256 bytes, reached directly or via the pointer.
package pmm_pkg;

  localparam int PC_W = 13;
  localparam int PROG_AW = 12;
  localparam int PROG_WORD_W = 14;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  localparam int OFS_W = 7;
  localparam int DADDR_W = 9;
  localparam int PTR_W = 8;
  localparam int GPR_DEPTH = 256;
  localparam int GPR_IDX_W = 8;

  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam logic [6:0] COMMON_BASE = 7'h70;
  localparam logic [7:0] BANK1_GPR_START = 8'h60;
  localparam logic [7:0] BANK2_GPR_START = 8'hB0;

  // Offsets decoded to the bank 0 register from every bank
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_PCLOW = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_PCHIGH = 7'h0A;
  localparam logic [6:0] OFS_INTCTL = 7'h0B;
  // Offsets that banks 2 and 3 share with banks 0 and 1
  localparam logic [6:0] OFS_PAIR_A = 7'h01;
  localparam logic [6:0] OFS_PAIR_LO = 7'h05;
  localparam logic [6:0] OFS_PAIR_HI = 7'h07;

  typedef enum logic [2:0] {
    PMM_KIND_NONE = 3'h1,
    PMM_KIND_SFR = 3'h2,
    PMM_KIND_GPR = 3'h4
  } pmm_kind_t;

endpackage : pmm_pkg

// ### logic/pmm_data_if.sv
/*
  Carrier between the map top and its data address decoder.
  Assumes both ends sit in the same clock domain; the decoder is purely combinational.
*/
interface pmm_data_if;
  logic bank_select_low_bit;
  logic bank_select_high_bit;
  logic indirect;
  logic [pmm_pkg::OFS_W-1:0] offset;
  logic [pmm_pkg::PTR_W-1:0] file_select_pointer;
  logic [pmm_pkg::DADDR_W-1:0] full_addr;
  pmm_pkg::pmm_kind_t kind;
  logic [pmm_pkg::DADDR_W-1:0] sfr_addr;
  logic [pmm_pkg::GPR_IDX_W-1:0] gpr_idx;

  modport requester (
    output bank_select_low_bit, bank_select_high_bit, indirect, offset, file_select_pointer,
    input full_addr, kind, sfr_addr, gpr_idx
  );
  modport decoder (
    input bank_select_low_bit, bank_select_high_bit, indirect, offset, file_select_pointer,
    output full_addr, kind, sfr_addr, gpr_idx
  );
endinterface : pmm_data_if

// ### logic/pmm_data_decode.sv
/*
  Data address decoder: forms the 9-bit data address and classifies it.
  Assumes the requester holds its inputs stable for the cycle it samples the answer.
*/
module pmm_data_decode (
  pmm_data_if.decoder dif // Request in, decoded address out
);

  logic [1:0] bank;
  logic [6:0] ofs;

  // Position inside a bank's RAM window, counted from its first RAM byte
  function automatic logic [7:0] ram_rel(input logic [6:0] o);
    return {1'b0, o - pmm_pkg::GPR_BASE};
  endfunction : ram_rel

  always_comb begin
    if (dif.indirect) begin
      dif.full_addr = {dif.bank_select_high_bit, dif.file_select_pointer};
    end else begin
      dif.full_addr = {dif.bank_select_high_bit, dif.bank_select_low_bit, dif.offset};
    end
  end

  assign bank = dif.full_addr[8:7];
  assign ofs = dif.full_addr[6:0];

  always_comb begin
    dif.kind = pmm_pkg::PMM_KIND_NONE;
    dif.sfr_addr = '0;
    dif.gpr_idx = '0;
    if (ofs < pmm_pkg::GPR_BASE) begin
      if (ofs == pmm_pkg::OFS_INDIRECT || ofs == pmm_pkg::OFS_PCLOW ||
          ofs == pmm_pkg::OFS_STATUS || ofs == pmm_pkg::OFS_POINTER ||
          ofs == pmm_pkg::OFS_PCHIGH || ofs == pmm_pkg::OFS_INTCTL) begin
        dif.kind = pmm_pkg::PMM_KIND_SFR;
        dif.sfr_addr = {2'h0, ofs};
      end else if (bank[1] && (ofs == pmm_pkg::OFS_PAIR_A ||
                   (ofs >= pmm_pkg::OFS_PAIR_LO && ofs <= pmm_pkg::OFS_PAIR_HI))) begin
        dif.kind = pmm_pkg::PMM_KIND_SFR;
        dif.sfr_addr = {1'b0, bank[0], ofs};
      end else if (!bank[1]) begin
        dif.kind = pmm_pkg::PMM_KIND_SFR;
        dif.sfr_addr = dif.full_addr;
      end
    end else if (ofs >= pmm_pkg::COMMON_BASE || bank == 2'h0) begin
      // Top sixteen bytes of every bank land on bank 0 storage
      dif.kind = pmm_pkg::PMM_KIND_GPR;
      dif.gpr_idx = ram_rel(ofs);
    end else if (bank == 2'h1) begin
      dif.kind = pmm_pkg::PMM_KIND_GPR;
      dif.gpr_idx = pmm_pkg::BANK1_GPR_START + ram_rel(ofs);
    end else if (bank == 2'h2) begin
      dif.kind = pmm_pkg::PMM_KIND_GPR;
      dif.gpr_idx = pmm_pkg::BANK2_GPR_START + ram_rel(ofs);
    end
  end

endmodule : pmm_data_decode

// ### logic/pmm_memory_map.sv
/*
  Program and data memory map of the core: program counter with vectors and
  wraparound, data address forming and decode, and the 256-byte register RAM.
  Assumes all inputs come from core logic on clk, so none are synchronised.
*/
module pmm_memory_map (
  input wire logic clk, // Core clock, 100 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic pc_step, // Advance to the next instruction
  input wire logic pc_load, // Load pc_target (jump, call, return)
  input wire logic [pmm_pkg::PC_W-1:0] pc_target, // Jump target
  input wire logic irq_take, // Interrupt accepted this cycle
  input wire logic acc_valid, // Data access request
  input wire logic acc_write, // Request is a write
  input wire logic acc_indirect, // Use file_select_pointer as address
  input wire logic bank_select_low_bit, // Bank select, low bit
  input wire logic bank_select_high_bit, // Bank select, high bit
  input wire logic [pmm_pkg::OFS_W-1:0] acc_offset, // In-bank offset from instruction
  input wire logic [pmm_pkg::PTR_W-1:0] file_select_pointer, // Indirect pointer value
  input wire logic [7:0] acc_wdata, // Write data
  output logic [pmm_pkg::PC_W-1:0] pc_reg, // Program counter
  output logic [pmm_pkg::PROG_AW-1:0] prog_addr_reg, // Fetch address into the store
  output logic [pmm_pkg::DADDR_W-1:0] data_addr_reg, // Full data address
  output pmm_pkg::pmm_kind_t kind_reg, // Access class
  output logic [pmm_pkg::DADDR_W-1:0] sfr_addr_reg, // Register address after mirroring
  output logic [pmm_pkg::GPR_IDX_W-1:0] gpr_idx_reg, // RAM index
  output logic dvalid_reg, // Decoded outputs valid
  output logic rvalid_reg, // RAM read data valid
  output logic [7:0] rdata_reg // RAM read data
);

  logic [pmm_pkg::PC_W-1:0] pc_next;
  logic [7:0] gpr_mem [pmm_pkg::GPR_DEPTH];
  logic gpr_hit;

  pmm_data_if dif ();

  assign dif.bank_select_low_bit = bank_select_low_bit;
  assign dif.bank_select_high_bit = bank_select_high_bit;
  assign dif.indirect = acc_indirect;
  assign dif.offset = acc_offset;
  assign dif.file_select_pointer = file_select_pointer;

  pmm_data_decode u_decode (
    .dif(dif.decoder)
  );

  // Interrupt outranks a jump, a jump outranks a plain step
  always_comb begin
    pc_next = pc_reg;
    if (irq_take) begin
      pc_next = pmm_pkg::IRQ_VECTOR;
    end else if (pc_load) begin
      pc_next = pc_target;
    end else if (pc_step) begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_reg <= pmm_pkg::RESET_VECTOR;
      prog_addr_reg <= 12'h000;
    end else begin
      pc_reg <= pc_next;
      // Only the low bits reach the store, so high addresses alias into it
      prog_addr_reg <= pc_next[pmm_pkg::PROG_AW-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_addr_reg <= '0;
      kind_reg <= pmm_pkg::PMM_KIND_NONE;
      sfr_addr_reg <= '0;
      gpr_idx_reg <= '0;
      dvalid_reg <= 1'b0;
    end else begin
      dvalid_reg <= acc_valid;
      if (acc_valid) begin
        data_addr_reg <= dif.full_addr;
        kind_reg <= dif.kind;
        sfr_addr_reg <= dif.sfr_addr;
        gpr_idx_reg <= dif.gpr_idx;
      end
    end
  end

  assign gpr_hit = acc_valid && (dif.kind == pmm_pkg::PMM_KIND_GPR);

  // RAM has no reset; contents are undefined until software writes them
  always_ff @(posedge clk) begin
    if (gpr_hit && acc_write) begin
      gpr_mem[dif.gpr_idx] <= acc_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      rvalid_reg <= gpr_hit && !acc_write;
      if (gpr_hit && !acc_write) begin
        rdata_reg <= gpr_mem[dif.gpr_idx];
      end
    end
  end

  // Checks

  sequence s_gpr_write;
    acc_valid && acc_write && dif.kind == pmm_pkg::PMM_KIND_GPR;
  endsequence

  sequence s_same_read;
    acc_valid && !acc_write && dif.kind == pmm_pkg::PMM_KIND_GPR &&
      dif.gpr_idx == $past(dif.gpr_idx);
  endsequence

  a_reset_vector: assert property (@(posedge clk)
    $past(rst) && !rst |-> pc_reg == 13'h0000 && prog_addr_reg == 12'h000)
    else $error("fetch did not start at the reset vector");

  a_irq_vector: assert property (@(posedge clk) disable iff (rst)
    irq_take |=> pc_reg == 13'h0004 && prog_addr_reg == 12'h004)
    else $error("interrupt did not redirect fetch to 0004h");

  a_pc_step: assert property (@(posedge clk) disable iff (rst)
    pc_step && !pc_load && !irq_take |=> pc_reg == $past(pc_reg) + 13'h0001)
    else $error("program counter did not advance by one");

  a_fetch_wrap: assert property (@(posedge clk) disable iff (rst)
    pc_load && !irq_take && pc_target[12] |=>
      prog_addr_reg == $past(pc_target[11:0]) && pc_reg[12])
    else $error("high program address did not wrap into the store");

  a_bank_select: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_indirect |=>
      data_addr_reg[8:7] == $past({bank_select_high_bit, bank_select_low_bit}))
    else $error("wrong bank selected");

  a_direct_addr: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_indirect |=> dvalid_reg &&
      data_addr_reg == $past({bank_select_high_bit, bank_select_low_bit, acc_offset}))
    else $error("direct address not formed from bank bits and offset");

  a_common_ram: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[6:0] >= 7'h70 |=>
      kind_reg == pmm_pkg::PMM_KIND_GPR && gpr_idx_reg == {1'b0, $past(dif.full_addr[6:0]) - 7'h20})
    else $error("top of bank did not reach shared bank 0 storage");

  a_low_is_sfr: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[6:0] < 7'h20 |=> kind_reg != pmm_pkg::PMM_KIND_GPR)
    else $error("low offset decoded to RAM");

  a_status_mirror: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[6:0] == 7'h03 |=>
      kind_reg == pmm_pkg::PMM_KIND_SFR && sfr_addr_reg == 9'h003)
    else $error("status register not shared across banks");

  a_ram_readback: assert property (@(posedge clk) disable iff (rst)
    s_gpr_write ##1 s_same_read |=> rvalid_reg && rdata_reg == $past(acc_wdata, 2))
    else $error("RAM read did not return the written byte");

  sequence s_ram_read;
    acc_valid && !acc_write && dif.kind == pmm_pkg::PMM_KIND_GPR;
  endsequence

  a_fetch_alias: assert property (@(posedge clk) disable iff (rst)
    prog_addr_reg == pc_reg[pmm_pkg::PROG_AW-1:0])
    else $error("fetch address differs from the low counter bits");

  a_pc_load: assert property (@(posedge clk) disable iff (rst)
    pc_load && !irq_take |=> pc_reg == $past(pc_target))
    else $error("program counter did not take the jump target");

  a_pc_hold: assert property (@(posedge clk) disable iff (rst)
    !pc_step && !pc_load && !irq_take |=> pc_reg == $past(pc_reg))
    else $error("program counter moved with no request");

  a_indirect_addr: assert property (@(posedge clk) disable iff (rst)
    acc_valid && acc_indirect |=>
      data_addr_reg == $past({bank_select_high_bit, file_select_pointer}))
    else $error("indirect address not formed from the pointer");

  // Decode outputs must hold between requests so the core can read them late
  a_decode_quiet: assert property (@(posedge clk) disable iff (rst)
    !acc_valid |=> !dvalid_reg && $stable(data_addr_reg) && $stable(kind_reg))
    else $error("decode outputs moved with no request");

  a_read_valid: assert property (@(posedge clk) disable iff (rst)
    s_ram_read |=> rvalid_reg)
    else $error("RAM read gave no valid strobe");

  a_read_quiet: assert property (@(posedge clk) disable iff (rst)
    !(acc_valid && !acc_write && dif.kind == pmm_pkg::PMM_KIND_GPR) |=> !rvalid_reg)
    else $error("read strobe without a RAM read");

  a_unused_bank: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[8:7] == 2'h3 && dif.full_addr[6:0] >= 7'h20 &&
      dif.full_addr[6:0] < 7'h70 |=> kind_reg == pmm_pkg::PMM_KIND_NONE)
    else $error("unimplemented RAM window decoded as storage");

  a_bank0_ram: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[8:7] == 2'h0 && dif.full_addr[6:0] >= 7'h20 |=>
      kind_reg == pmm_pkg::PMM_KIND_GPR &&
      gpr_idx_reg == {1'b0, $past(dif.full_addr[6:0]) - 7'h20})
    else $error("bank 0 RAM index wrong");

  // Bank 1 window starts at index 60h, so the index is the offset plus 40h
  a_bank1_ram: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[8:7] == 2'h1 && dif.full_addr[6:0] >= 7'h20 &&
      dif.full_addr[6:0] < 7'h70 |=>
      kind_reg == pmm_pkg::PMM_KIND_GPR &&
      gpr_idx_reg == 8'h40 + {1'b0, $past(dif.full_addr[6:0])})
    else $error("bank 1 RAM index wrong");

  // Bank 2 window starts at index B0h, so the index is the offset plus 90h
  a_bank2_ram: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[8:7] == 2'h2 && dif.full_addr[6:0] >= 7'h20 &&
      dif.full_addr[6:0] < 7'h70 |=>
      kind_reg == pmm_pkg::PMM_KIND_GPR &&
      gpr_idx_reg == 8'h90 + {1'b0, $past(dif.full_addr[6:0])})
    else $error("bank 2 RAM index wrong");

  a_pair_mirror: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[8] && dif.full_addr[6:0] == 7'h01 |=>
      kind_reg == pmm_pkg::PMM_KIND_SFR &&
      sfr_addr_reg == {1'b0, $past(dif.full_addr[7]), 7'h01})
    else $error("shared register of the upper banks not mirrored");

  a_low_sfr_zero: assert property (@(posedge clk) disable iff (rst)
    acc_valid && dif.full_addr[6:0] < 7'h20 |=> gpr_idx_reg == 8'h00)
    else $error("register access left a RAM index");

endmodule : pmm_memory_map

// ### dv/pmm_core_model.sv
/*
  Model of the core fetch and operand logic that drives the memory map.
  Assumes one core clock; every request is changed on the falling edge.
*/
module pmm_core_model (
  input wire logic clk, // Core clock
  output logic pc_step, // Advance request
  output logic pc_load, // Jump request
  output logic [pmm_pkg::PC_W-1:0] pc_target, // Jump target
  output logic irq_take, // Interrupt accepted
  output logic acc_valid, // Data request
  output logic acc_write, // Write request
  output logic acc_indirect, // Pointer addressing
  output logic bank_select_low_bit, // Bank bit low
  output logic bank_select_high_bit, // Bank bit high
  output logic [pmm_pkg::OFS_W-1:0] acc_offset, // In-bank offset
  output logic [pmm_pkg::PTR_W-1:0] file_select_pointer, // Pointer value
  output logic [7:0] acc_wdata // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {pc_step, pc_load, irq_take, acc_valid, acc_write, acc_indirect} = 6'h00;
    {bank_select_low_bit, bank_select_high_bit} = 2'h0;
    pc_target = 13'h0000;
    acc_offset = 7'h00;
    file_select_pointer = 8'h00;
    acc_wdata = 8'h00;
  end
  task automatic put(input logic wr, input logic ind, input logic hi, input logic lo,
                     input logic [6:0] ofs, input logic [7:0] ptr, input logic [7:0] wd);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_indirect = ind;
    bank_select_high_bit = hi;
    bank_select_low_bit = lo;
    acc_offset = ofs;
    file_select_pointer = ptr;
    acc_wdata = wd;
  endtask : put
  // Released offset, pointer and write data flip so that a design sampling them late sees garbage
  task automatic idle();
    @(negedge clk);
    acc_valid = 1'b0;
    acc_offset = ~acc_offset;
    file_select_pointer = ~file_select_pointer;
    acc_wdata = ~acc_wdata;
  endtask : idle
  task automatic acc(input logic wr, input logic ind, input logic hi, input logic lo,
                     input logic [6:0] ofs, input logic [7:0] ptr, input logic [7:0] wd);
    put(wr, ind, hi, lo, ofs, ptr, wd);
    idle();
  endtask : acc
  task automatic pc_op(input logic st, input logic ld, input logic ir, input logic [12:0] tgt);
    @(negedge clk);
    pc_step = st;
    pc_load = ld;
    irq_take = ir;
    pc_target = tgt;
    @(negedge clk);
    {pc_step, pc_load, irq_take} = 3'h0;
    pc_target = ~tgt;
  endtask : pc_op
endmodule : pmm_core_model

// ### dv/testbench.sv
/*
  Self-checking bench for the memory map: program counter and data decode.
  Assumes the core model drives all requests; expectations come from the map rules.
*/
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst, pc_step, pc_load, irq_take, acc_valid, acc_write, acc_indirect;
  logic bank_select_low_bit, bank_select_high_bit, dvalid_reg, rvalid_reg;
  logic [12:0] pc_target, pc_reg;
  logic [11:0] prog_addr_reg;
  logic [6:0] acc_offset;
  logic [7:0] file_select_pointer, acc_wdata, gpr_idx_reg, rdata_reg;
  logic [8:0] data_addr_reg, sfr_addr_reg;
  pmm_pkg::pmm_kind_t kind_reg;
  int mismatches = 0;
  int samples_checked = 0;
  pmm_core_model u_pmm_core_model (.clk(clk), .pc_step(pc_step), .pc_load(pc_load),
    .pc_target(pc_target), .irq_take(irq_take), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_indirect(acc_indirect), .bank_select_low_bit(bank_select_low_bit),
    .bank_select_high_bit(bank_select_high_bit), .acc_offset(acc_offset),
    .file_select_pointer(file_select_pointer), .acc_wdata(acc_wdata));
  pmm_memory_map u_pmm_memory_map (.clk(clk), .rst(rst), .pc_step(pc_step), .pc_load(pc_load),
    .pc_target(pc_target), .irq_take(irq_take), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_indirect(acc_indirect), .bank_select_low_bit(bank_select_low_bit),
    .bank_select_high_bit(bank_select_high_bit), .acc_offset(acc_offset),
    .file_select_pointer(file_select_pointer), .acc_wdata(acc_wdata), .pc_reg(pc_reg),
    .prog_addr_reg(prog_addr_reg), .data_addr_reg(data_addr_reg), .kind_reg(kind_reg),
    .sfr_addr_reg(sfr_addr_reg), .gpr_idx_reg(gpr_idx_reg), .dvalid_reg(dvalid_reg),
    .rvalid_reg(rvalid_reg), .rdata_reg(rdata_reg));
  // Clock starts low from its declaration, so time zero shows no false falling edge
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic t_pc();
    u_pmm_core_model.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    `CHK(pc_reg, 13'h0001)
    u_pmm_core_model.pc_op(1'b0, 1'b1, 1'b0, 13'h1ABC);
    `CHK(prog_addr_reg, 12'hABC)
    `CHK(pc_reg, 13'h1ABC)
    u_pmm_core_model.pc_op(1'b0, 1'b1, 1'b0, 13'h1FFF);
    u_pmm_core_model.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    `CHK(pc_reg, 13'h0000)
    u_pmm_core_model.pc_op(1'b1, 1'b1, 1'b0, 13'h0123);
    `CHK(pc_reg, 13'h0123)
    u_pmm_core_model.pc_op(1'b1, 1'b1, 1'b1, 13'h0777);
    `CHK(pc_reg, 13'h0004)
    `CHK(prog_addr_reg, 12'h004)
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    `CHK(pc_reg, 13'h0000)
    `CHK(prog_addr_reg, 12'h000)
    $display("test pc done");
  endtask : t_pc
  task automatic chk_dec(input logic hi, input logic lo, input logic [6:0] ofs,
                         input logic [8:0] ea, input pmm_pkg::pmm_kind_t ek,
                         input logic [8:0] es, input logic [7:0] eg);
    u_pmm_core_model.acc(1'b0, 1'b0, hi, lo, ofs, 8'h00, 8'h00);
    `CHK(dvalid_reg, 1'b1)
    `CHK(data_addr_reg, ea)
    `CHK(kind_reg, ek)
    `CHK(sfr_addr_reg, es)
    `CHK(gpr_idx_reg, eg)
    `CHK(rvalid_reg, ek == pmm_pkg::PMM_KIND_GPR)
  endtask : chk_dec
  task automatic t_banks();
    chk_dec(1'b0, 1'b0, 7'h25, 9'h025, pmm_pkg::PMM_KIND_GPR, 9'h000, 8'h05);
    chk_dec(1'b0, 1'b1, 7'h25, 9'h0A5, pmm_pkg::PMM_KIND_GPR, 9'h000, 8'h65);
    chk_dec(1'b1, 1'b0, 7'h25, 9'h125, pmm_pkg::PMM_KIND_GPR, 9'h000, 8'hB5);
    chk_dec(1'b1, 1'b1, 7'h25, 9'h1A5, pmm_pkg::PMM_KIND_NONE, 9'h000, 8'h00);
    chk_dec(1'b1, 1'b1, 7'h7F, 9'h1FF, pmm_pkg::PMM_KIND_GPR, 9'h000, 8'h5F);
    chk_dec(1'b0, 1'b1, 7'h72, 9'h0F2, pmm_pkg::PMM_KIND_GPR, 9'h000, 8'h52);
    chk_dec(1'b0, 1'b0, 7'h0C, 9'h00C, pmm_pkg::PMM_KIND_SFR, 9'h00C, 8'h00);
    chk_dec(1'b0, 1'b1, 7'h0C, 9'h08C, pmm_pkg::PMM_KIND_SFR, 9'h08C, 8'h00);
    chk_dec(1'b1, 1'b1, 7'h0C, 9'h18C, pmm_pkg::PMM_KIND_NONE, 9'h000, 8'h00);
    chk_dec(1'b1, 1'b0, 7'h03, 9'h103, pmm_pkg::PMM_KIND_SFR, 9'h003, 8'h00);
    chk_dec(1'b1, 1'b0, 7'h06, 9'h106, pmm_pkg::PMM_KIND_SFR, 9'h006, 8'h00);
    chk_dec(1'b1, 1'b1, 7'h01, 9'h181, pmm_pkg::PMM_KIND_SFR, 9'h081, 8'h00);
    @(negedge clk);
    `CHK(dvalid_reg, 1'b0)
    $display("test banks done");
  endtask : t_banks
  // Write through the pointer, read it back directly on the next cycle; then a pointer
  // write with both bank bits set must land in bank 2, as the low bit plays no part
  task automatic t_ram();
    u_pmm_core_model.put(1'b1, 1'b1, 1'b0, 1'b0, 7'h00, 8'hA5, 8'h5A);
    u_pmm_core_model.acc(1'b0, 1'b0, 1'b0, 1'b1, 7'h25, 8'h00, 8'h00);
    `CHK(rvalid_reg, 1'b1)
    `CHK(rdata_reg, 8'h5A)
    `CHK(gpr_idx_reg, 8'h65)
    u_pmm_core_model.acc(1'b1, 1'b1, 1'b1, 1'b1, 7'h00, 8'h25, 8'hC3);
    `CHK(data_addr_reg, 9'h125)
    `CHK(rvalid_reg, 1'b0)
    u_pmm_core_model.acc(1'b0, 1'b0, 1'b1, 1'b0, 7'h25, 8'h00, 8'h00);
    `CHK(rdata_reg, 8'hC3)
    `CHK(gpr_idx_reg, 8'hB5)
    $display("test ram done");
  endtask : t_ram
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    `CHK(pc_reg, 13'h0000)
    `CHK(kind_reg, pmm_pkg::PMM_KIND_NONE)
    $display("test reset done");
    t_pc();
    t_banks();
    t_ram();
    end_of_test();
  end
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule : testbench
